// *** src/blink_phase_gen.sv ***
// Blink phase generator: toggles between the even and odd half phases.
`timescale 1ns/10ps
module blink_phase_gen #(
  parameter int unsigned HALF_CYCLES = lcd_ext_pkg::BLINK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic odd_phase
);

  typedef struct packed {
    logic [lcd_ext_pkg::BLINK_CNT_W-1:0] count;
    logic odd;
  } blink_state_s;

  localparam logic [lcd_ext_pkg::BLINK_CNT_W-1:0] LAST =
    lcd_ext_pkg::BLINK_CNT_W'(HALF_CYCLES - 1);

  blink_state_s st_reg;
  blink_state_s st_next;

  // Counts one half phase, then flips the phase and restarts.
  always_comb begin
    st_next = st_reg;
    if (st_reg.count == LAST) begin
      st_next.count = '0;
      st_next.odd = ~st_reg.odd;
    end else begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign odd_phase = st_reg.odd;

  AST_PHASE_FLIP: assert property (@(posedge clk) disable iff (!arst_n)
    (st_reg.count == LAST) |=> (st_reg.odd != $past(st_reg.odd)))
    else $error("Blink phase did not flip at the end of a half phase.");

endmodule

// *** src/icon_map.sv ***
// Icon map: holds the icon words of the character generator RAM and drives 160 icon states.
`timescale 1ns/10ps
module icon_map (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [lcd_ext_pkg::CG_ADDR_W-1:0] wr_addr,
  input wire logic [lcd_ext_pkg::CG_DATA_W-1:0] wr_data,
  input wire logic blink_en,
  input wire logic odd_phase,
  output logic [lcd_ext_pkg::ICON_COUNT-1:0] icons
);

  typedef struct packed {
    logic [lcd_ext_pkg::ICON_COUNT-1:0] icons;
  } icon_state_s;

  logic [lcd_ext_pkg::CG_DATA_W-1:0] char_generator_ram [lcd_ext_pkg::CG_DEPTH];
  icon_state_s st_reg;
  icon_state_s st_next;
  logic use_odd;

  assign use_odd = blink_en & odd_phase;

  // Unpacks five icons per word; bit 4 is the first icon of the word.
  always_comb begin
    logic [lcd_ext_pkg::CG_ADDR_W-1:0] base;
    base = use_odd ? lcd_ext_pkg::ODD_PHASE_BASE : '0;
    st_next = st_reg;
    for (int a = 0; a < lcd_ext_pkg::ICON_WORDS; a++) begin
      for (int b = 0; b < lcd_ext_pkg::ICON_PER_WORD; b++) begin
        // A set bit lights the icon, a clear bit blanks it.
        st_next.icons[a * lcd_ext_pkg::ICON_PER_WORD + (lcd_ext_pkg::ICON_PER_WORD - 1 - b)] =
          char_generator_ram[base + lcd_ext_pkg::CG_ADDR_W'(a)][b];
      end
    end
  end

  // Stores icon words written by software; every word clears on reset, so no icon reads unknown.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < lcd_ext_pkg::CG_DEPTH; i++) begin
        char_generator_ram[i] <= '0;
      end
    end else if (wr_en) begin
      char_generator_ram[wr_addr] <= wr_data;
    end
  end

  // Registers the icon states.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign icons = st_reg.icons;

  AST_EVEN_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
    !use_odd |=> (icons[0] == $past(char_generator_ram[0][4])))
    else $error("Icon 1 not taken from word 0 in the even phase.");

  AST_ODD_LAST: assert property (@(posedge clk) disable iff (!arst_n)
    use_odd |=> (icons[159] == $past(char_generator_ram[63][0])))
    else $error("Icon 160 not taken from word 63 in the odd phase.");

  AST_ROW18_START: assert property (@(posedge clk) disable iff (!arst_n)
    !use_odd |=> (icons[80] == $past(char_generator_ram[16][4])))
    else $error("Icon 81 not taken from word 16.");

endmodule

// *** src/lcd_ext_pkg.sv ***
// Package of constants, types and instruction codes for the LCD extended configuration block.
package lcd_ext_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // Clock rate and the blink divider; a full blink period spans the divider.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BLINK_DIVIDER = 52224;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_DIVIDER / 2;
  localparam int unsigned BLINK_CNT_W = 15;

  // ==========================================================================
  // Icon memory geometry
  // ==========================================================================
  localparam int unsigned ICON_COUNT = 160;
  localparam int unsigned ICON_PER_WORD = 5;
  localparam int unsigned ICON_WORDS = 32;
  localparam int unsigned ICON_ROW18_WORD = 16;
  localparam int unsigned CG_ADDR_W = 6;
  localparam int unsigned CG_DATA_W = 5;
  localparam int unsigned CG_DEPTH = 64;
  localparam logic [5:0] ODD_PHASE_BASE = 6'h20;

  // ==========================================================================
  // Voltage levels and drive ratios
  // ==========================================================================
  localparam int unsigned LEVEL_W = 6;
  localparam logic [5:0] LEVEL_OFF = 6'h00;
  localparam logic [4:0] RATIO_ICON = 5'h02;
  localparam logic [4:0] RATIO_CHAR = 5'h12;

  // Extended configuration held by the device; layout is also the read-back layout.
  typedef struct packed {
    logic [5:0] level_icon;
    logic [5:0] level_char;
    logic temp_coef_bit_high;
    logic temp_coef_bit_low;
    logic row_mirror;
    logic col_mirror;
    logic split_mirror;
    logic [1:0] mult_stages;
    logic direct_supply_mode;
    logic icon_blink_enable;
    logic icon_mode_select;
  } ext_cfg_s;

  localparam ext_cfg_s EXT_CFG_RESET = '0;

  // ==========================================================================
  // Instruction codes (mask and pattern pairs)
  // ==========================================================================
  localparam logic [7:0] OP_FUNC_MASK = 8'he0;
  localparam logic [7:0] OP_FUNC_PAT = 8'h20;
  localparam int unsigned FUNC_EXT_BIT = 0;
  localparam logic [7:0] OP_ICON_MASK = 8'hf8;
  localparam logic [7:0] OP_ICON_PAT = 8'h08;
  localparam int unsigned ICON_IM_BIT = 2;
  localparam int unsigned ICON_IB_BIT = 1;
  localparam int unsigned ICON_DM_BIT = 0;
  localparam logic [7:0] OP_STAGE_MASK = 8'hfc;
  localparam logic [7:0] OP_STAGE_PAT = 8'h40;
  localparam logic [7:0] OP_TEMP_MASK = 8'hfc;
  localparam logic [7:0] OP_TEMP_PAT = 8'h04;
  localparam int unsigned TEMP_HIGH_BIT = 1;
  localparam int unsigned TEMP_LOW_BIT = 0;
  localparam logic [7:0] OP_SCREEN_MASK = 8'hfe;
  localparam logic [7:0] OP_SCREEN_PAT = 8'h02;
  localparam int unsigned SCREEN_L_BIT = 0;
  localparam logic [7:0] OP_DISP_MASK = 8'hfc;
  localparam logic [7:0] OP_DISP_PAT = 8'h10;
  localparam int unsigned DISP_COL_BIT = 1;
  localparam int unsigned DISP_ROW_BIT = 0;
  localparam logic [7:0] OP_VSET_MASK = 8'hc0;
  localparam logic [7:0] OP_VSET_CHAR = 8'h80;
  localparam logic [7:0] OP_VSET_ICON = 8'hc0;

  // ==========================================================================
  // Register bus
  // ==========================================================================
  localparam int unsigned AXI_ADDR_W = 5;
  localparam logic [4:0] REG_INSTR = 5'h00;
  localparam logic [4:0] REG_CHAR_GENERATOR_RAM = 5'h04;
  localparam logic [4:0] REG_CTRL = 5'h08;
  localparam logic [4:0] REG_CONFIG = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int unsigned CG_WADDR_LSB = 8;
  localparam int unsigned CTRL_DISP_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** src/lcd_icon_and_extended_config.sv ***
// Extended configuration, voltage control and icon drive of the LCD controller, on AXI4-Lite.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module lcd_icon_and_extended_config #(
  parameter int unsigned BLINK_HALF_CYCLES = lcd_ext_pkg::BLINK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [lcd_ext_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lcd_ext_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_input,
  output lcd_ext_pkg::ext_cfg_s ext_cfg,
  output logic ext_select,
  output logic voltage_generator_en,
  output logic [lcd_ext_pkg::LEVEL_W-1:0] vlcd_level,
  output logic direct_supply_connect,
  output logic [4:0] drive_ratio,
  output logic blink_odd_phase,
  output logic [lcd_ext_pkg::ICON_COUNT-1:0] icon_state
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic ext_sel;
    lcd_ext_pkg::ext_cfg_s cfg;
    logic display_on;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic have_aw;
    logic have_w;
    logic [lcd_ext_pkg::AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic cg_wr;
    logic [lcd_ext_pkg::CG_ADDR_W-1:0] cg_addr;
    logic [lcd_ext_pkg::CG_DATA_W-1:0] cg_data;
    logic gen_en;
    logic [lcd_ext_pkg::LEVEL_W-1:0] vlcd;
    logic direct_out;
    logic [4:0] ratio;
  } top_state_s;

  top_state_s st_reg;
  top_state_s st_next;
  logic odd_phase;
  logic exec_w;
  logic instr_fire;
  logic [7:0] instr_byte;
  logic [lcd_ext_pkg::LEVEL_W-1:0] sel_level;

  // Matches an instruction byte against a mask and pattern.
  function automatic logic op_is(input logic [7:0] code, input logic [7:0] mask,
                                 input logic [7:0] pat);
    op_is = (code & mask) == pat;
  endfunction

  // ==========================================================================
  // Submodules
  // ==========================================================================
  blink_phase_gen #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .clk(clk),
    .arst_n(arst_n),
    .odd_phase(odd_phase)
  );

  icon_map u_icons (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(st_reg.cg_wr),
    .wr_addr(st_reg.cg_addr),
    .wr_data(st_reg.cg_data),
    .blink_en(st_reg.cfg.icon_blink_enable),
    .odd_phase(odd_phase),
    .icons(icon_state)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // A write executes once both address and data are held and no response is pending.
  assign exec_w = st_reg.have_aw & st_reg.have_w & ~st_reg.bvalid;
  assign instr_fire = exec_w & (st_reg.aw_addr == lcd_ext_pkg::REG_INSTR) & st_reg.w_strb[0];
  assign instr_byte = st_reg.w_data[7:0];
  assign sel_level = st_reg.cfg.icon_mode_select ? st_reg.cfg.level_icon :
                     st_reg.cfg.level_char;

  // Bus handshakes, instruction decode, register reads and derived outputs.
  always_comb begin
    st_next = st_reg;
    st_next.pd_meta = power_down_input;
    st_next.pd_sync = st_reg.pd_meta;
    st_next.cg_wr = 1'b0;
    // Address and data channels are taken independently.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.have_aw = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.have_w = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (exec_w) begin
      st_next.have_aw = 1'b0;
      st_next.have_w = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = lcd_ext_pkg::RESP_OKAY;
      if (st_reg.aw_addr == lcd_ext_pkg::REG_INSTR) begin
        if (instr_fire && op_is(instr_byte, lcd_ext_pkg::OP_FUNC_MASK,
                                lcd_ext_pkg::OP_FUNC_PAT)) begin
          st_next.ext_sel = instr_byte[lcd_ext_pkg::FUNC_EXT_BIT];
        end else if (instr_fire && st_reg.ext_sel) begin
          // Extended codes only; in the normal set they leave the settings alone.
          if (op_is(instr_byte, lcd_ext_pkg::OP_VSET_MASK, lcd_ext_pkg::OP_VSET_ICON)) begin
            st_next.cfg.level_icon = instr_byte[lcd_ext_pkg::LEVEL_W-1:0];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_VSET_MASK,
                             lcd_ext_pkg::OP_VSET_CHAR)) begin
            st_next.cfg.level_char = instr_byte[lcd_ext_pkg::LEVEL_W-1:0];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_ICON_MASK,
                             lcd_ext_pkg::OP_ICON_PAT)) begin
            st_next.cfg.icon_mode_select = instr_byte[lcd_ext_pkg::ICON_IM_BIT];
            st_next.cfg.icon_blink_enable = instr_byte[lcd_ext_pkg::ICON_IB_BIT];
            st_next.cfg.direct_supply_mode = instr_byte[lcd_ext_pkg::ICON_DM_BIT];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_STAGE_MASK,
                             lcd_ext_pkg::OP_STAGE_PAT)) begin
            st_next.cfg.mult_stages = instr_byte[1:0];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_TEMP_MASK,
                             lcd_ext_pkg::OP_TEMP_PAT)) begin
            st_next.cfg.temp_coef_bit_high = instr_byte[lcd_ext_pkg::TEMP_HIGH_BIT];
            st_next.cfg.temp_coef_bit_low = instr_byte[lcd_ext_pkg::TEMP_LOW_BIT];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_SCREEN_MASK,
                             lcd_ext_pkg::OP_SCREEN_PAT)) begin
            st_next.cfg.split_mirror = instr_byte[lcd_ext_pkg::SCREEN_L_BIT];
          end else if (op_is(instr_byte, lcd_ext_pkg::OP_DISP_MASK,
                             lcd_ext_pkg::OP_DISP_PAT)) begin
            st_next.cfg.col_mirror = instr_byte[lcd_ext_pkg::DISP_COL_BIT];
            st_next.cfg.row_mirror = instr_byte[lcd_ext_pkg::DISP_ROW_BIT];
          end
        end
      end else if (st_reg.aw_addr == lcd_ext_pkg::REG_CHAR_GENERATOR_RAM) begin
        st_next.cg_wr = st_reg.w_strb[0] & st_reg.w_strb[1];
        st_next.cg_addr = st_reg.w_data[lcd_ext_pkg::CG_WADDR_LSB +: lcd_ext_pkg::CG_ADDR_W];
        st_next.cg_data = st_reg.w_data[lcd_ext_pkg::CG_DATA_W-1:0];
      end else if (st_reg.aw_addr == lcd_ext_pkg::REG_CTRL) begin
        if (st_reg.w_strb[0]) begin
          st_next.display_on = st_reg.w_data[lcd_ext_pkg::CTRL_DISP_BIT];
        end
      end else if (st_reg.aw_addr == lcd_ext_pkg::REG_CONFIG ||
                   st_reg.aw_addr == lcd_ext_pkg::REG_STATUS) begin
        st_next.bresp = lcd_ext_pkg::RESP_OKAY; // Read-only; writes are ignored.
      end else begin
        st_next.bresp = lcd_ext_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read channel: one read at a time, data one edge after the address.
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = lcd_ext_pkg::RESP_OKAY;
      st_next.rdata = '0;
      if (s_axi_araddr == lcd_ext_pkg::REG_CTRL) begin
        st_next.rdata[lcd_ext_pkg::CTRL_DISP_BIT] = st_reg.display_on;
      end else if (s_axi_araddr == lcd_ext_pkg::REG_CONFIG) begin
        st_next.rdata = 32'(st_reg.cfg);
      end else if (s_axi_araddr == lcd_ext_pkg::REG_STATUS) begin
        st_next.rdata = 32'({odd_phase, st_reg.direct_out, st_reg.gen_en, st_reg.pd_sync,
                             st_reg.ext_sel});
      end else if (s_axi_araddr == lcd_ext_pkg::REG_INSTR ||
                   s_axi_araddr == lcd_ext_pkg::REG_CHAR_GENERATOR_RAM) begin
        st_next.rdata = '0;
      end else begin
        st_next.rresp = lcd_ext_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // Generator control: off in direct mode, at level zero, display off or power down.
    st_next.gen_en = ~st_reg.cfg.direct_supply_mode & (sel_level != lcd_ext_pkg::LEVEL_OFF) &
                     st_reg.display_on & ~st_reg.pd_sync;
    st_next.vlcd = sel_level;
    st_next.direct_out = st_reg.cfg.direct_supply_mode;
    st_next.ratio = st_reg.cfg.icon_mode_select ? lcd_ext_pkg::RATIO_ICON :
                    lcd_ext_pkg::RATIO_CHAR;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Registers all state; the write address, write data and read address channels are ready from reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.cfg <= lcd_ext_pkg::EXT_CFG_RESET;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.ratio <= lcd_ext_pkg::RATIO_CHAR;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register; blink_odd_phase comes from the blink generator and icon_state from the icon map.
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign ext_cfg = st_reg.cfg;
  assign ext_select = st_reg.ext_sel;
  assign voltage_generator_en = st_reg.gen_en;
  assign vlcd_level = st_reg.vlcd;
  assign direct_supply_connect = st_reg.direct_out;
  assign drive_ratio = st_reg.ratio;
  assign blink_odd_phase = odd_phase;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_VSET_CHAR: assert property (
    (instr_fire && st_reg.ext_sel && instr_byte[7:6] == 2'h2)
      |=> (st_reg.cfg.level_char == $past(instr_byte[5:0])))
    else $error("Character level not loaded by voltage set.");
  AST_VSET_ICON: assert property (
    (instr_fire && st_reg.ext_sel && instr_byte[7:6] == 2'h3)
      |=> (st_reg.cfg.level_icon == $past(instr_byte[5:0])))
    else $error("Icon level not loaded by voltage set.");
  AST_LEVEL_ZERO_OFF: assert property (
    (sel_level == 6'h00) |=> !voltage_generator_en)
    else $error("Generator on with selected level zero.");
  AST_DISP_PD_OFF: assert property (
    (!st_reg.display_on || st_reg.pd_sync) |=> !voltage_generator_en)
    else $error("Generator on during display off or power down.");
  AST_DIRECT: assert property (
    st_reg.cfg.direct_supply_mode |=> (!voltage_generator_en && direct_supply_connect))
    else $error("Direct mode did not bypass the generator.");
  AST_LEVEL_SEL: assert property (
    1'b1 |=> (vlcd_level == ($past(st_reg.cfg.icon_mode_select) ?
              $past(st_reg.cfg.level_icon) : $past(st_reg.cfg.level_char))))
    else $error("Wrong voltage level register selected.");
  AST_RATIO: assert property (
    st_reg.cfg.icon_mode_select |=> (drive_ratio == 5'h02))
    else $error("Icon mode not at ratio 1:2.");
  AST_HOLD_NORMAL: assert property (
    !(instr_fire && st_reg.ext_sel) |=> $stable(st_reg.cfg))
    else $error("Extended settings changed outside an extended instruction.");
  AST_GEN_ON: assert property (
    (!st_reg.cfg.direct_supply_mode && sel_level != 6'h00 && st_reg.display_on &&
     !st_reg.pd_sync) |=> voltage_generator_en)
    else $error("Generator off although all enables are met.");

endmodule

// *** verif/host_model.sv ***
// Host model: AXI4-Lite master that issues register writes and reads.
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  output logic [4:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [4:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  // All requests idle from time zero.
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  // Write offers address and data together and releases each once it is taken.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'h7};
    while (aw || w) begin
      @(posedge clk);
      if (awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask
  // Read holds the address until taken and rready until the data arrive.
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask
endmodule

// *** verif/lcd_icon_and_extended_config_bench.sv ***
// Testbench of the LCD extended configuration and icon block.
`timescale 1ns/10ps
module lcd_icon_and_extended_config_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic power_down_input = 1'b0;
  logic [4:0] awaddr, araddr, ratio;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic gen_en, direct, odd;
  logic [5:0] vlcd;
  logic [159:0] icons;
  logic [4:0] mem [64];
  logic [33:0] exp_q [$];
  logic [1:0] bexp_q [$];
  logic ext_sel;
  lcd_ext_pkg::ext_cfg_s cfg_out;
  lcd_ext_pkg::ext_cfg_s cfg;
  int error_cnt = 0;
  int tests_run = 0;
  // Clock of 50 ns period.
  initial forever #25 clk = ~clk;
  lcd_icon_and_extended_config #(.BLINK_HALF_CYCLES(8)) u_dut (.clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_down_input(power_down_input), .ext_cfg(cfg_out), .ext_select(ext_sel),
    .voltage_generator_en(gen_en), .vlcd_level(vlcd), .direct_supply_connect(direct),
    .drive_ratio(ratio), .blink_odd_phase(odd), .icon_state(icons));
  host_model u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));
  task automatic chk(input string n, input logic [159:0] e, input logic [159:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Each read or write answer is compared with the oldest expected note.
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk("read", exp_q.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", bexp_q.pop_front(), bresp);
  end
  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    bexp_q.push_back(e);
    u_host.wr(a, d);
  endtask
  task automatic ins(input logic [7:0] c);
    wr(lcd_ext_pkg::REG_INSTR, {24'h0, c}, lcd_ext_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Waits for the start of a phase so the check lands well inside it.
  task automatic at_phase(input logic p);
    while (odd === p) @(posedge clk);
    while (odd !== p) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    chk("phase", p, odd);
  endtask
  function automatic logic [159:0] icon_exp(input int base);
    logic [159:0] v;
    for (int i = 0; i < 160; i++) v[i] = mem[base + i / 5][4 - i % 5];
    return v;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h11191d75));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    wr(lcd_ext_pkg::REG_CTRL, 32'h1, lcd_ext_pkg::RESP_OKAY);
    wr(5'h14, 32'h1, lcd_ext_pkg::RESP_SLVERR);
    wr(lcd_ext_pkg::REG_CONFIG, 32'h3, lcd_ext_pkg::RESP_OKAY);
    rd(lcd_ext_pkg::REG_CTRL, 34'h1);
    rd(5'h14, {lcd_ext_pkg::RESP_SLVERR, 32'h0});
    $display("test bus done");
    ins(8'h21);
    chk("ext", 1'b1, ext_sel);
    ins(8'h95);
    ins(8'hea);
    ins(8'h42);
    ins(8'h06);
    ins(8'h03);
    ins(8'h13);
    ins(8'h20);
    chk("ext", 1'b0, ext_sel);
    ins(8'h80);
    cfg = '0;
    {cfg.level_icon, cfg.level_char, cfg.temp_coef_bit_high} = {6'h2a, 6'h15, 1'b1};
    {cfg.row_mirror, cfg.col_mirror, cfg.split_mirror, cfg.mult_stages} = 5'h1e;
    rd(lcd_ext_pkg::REG_CONFIG, {12'h0, cfg});
    chk("cfg", cfg, cfg_out);
    chk("level", 6'h15, vlcd);
    chk("ratio", 5'h12, ratio);
    chk("gen", 1'b1, gen_en);
    ins(8'h21);
    ins(8'h0c);
    chk("level", 6'h2a, vlcd);
    chk("ratio", 5'h02, ratio);
    ins(8'hc0);
    chk("gen", 1'b0, gen_en);
    ins(8'h09);
    chk("direct", 1'b1, direct);
    chk("gen", 1'b0, gen_en);
    ins(8'h08);
    @(posedge clk) power_down_input <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("gen", 1'b0, gen_en);
    @(posedge clk) power_down_input <= 1'b0;
    $display("test config done");
    for (int a = 0; a < 64; a++) begin
      mem[a] = 5'($urandom);
      wr(lcd_ext_pkg::REG_CHAR_GENERATOR_RAM, {18'h0, 6'(a), 3'h0, mem[a]}, lcd_ext_pkg::RESP_OKAY);
    end
    at_phase(1'b1);
    chk("icons", icon_exp(0), icons);
    ins(8'h0a);
    at_phase(1'b1);
    chk("icons", icon_exp(32), icons);
    at_phase(1'b0);
    chk("icons", icon_exp(0), icons);
    $display("test icons done");
    print_verdict();
  end
endmodule
